// ### verilog/spc_serial_port_control.sv
// control registers of two serial channels with interrupt gating
// assumes flags come from the serial cores on clk_i; standby from the
// power controller on clk_i
`default_nettype none
////////////////////////////////////////////////////////////////////
module spc_serial_port_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic standby_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial cores
  input wire spc_pkg::spc_flags_t [1:0] flags_i,
  input wire spc_pkg::spc_rx_ev_t [1:0] rx_ev_i,
  input wire logic [1:0] sck_pin_i,
  // controls and requests
  output spc_pkg::spc_ctl_t [1:0] ctl_o,
  output spc_pkg::spc_irq_t [1:0] irq_o,
  output logic irq_o_any
);
  logic [7:0] ctrl_q [spc_pkg::N_CH];
  logic [1:0] mode_q [spc_pkg::N_CH];
  logic [7:0] ev_q;
  logic [7:0] mask_q;
  logic [1:0] sck_s1_q;
  logic [1:0] sck_s2_q;
  logic [7:0] ev_set;
  logic req;
  logic wr_lo;
  logic [31:0] rd_d;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land on the edge that samples ack high, as the master expects
  assign wr_lo = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////
  // bus answer: one wait state, ack for a single cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      spc_pkg::ADDR_CTRL0: rd_d[7:0] = ctrl_q[0];
      spc_pkg::ADDR_CTRL1: rd_d[7:0] = ctrl_q[1];
      spc_pkg::ADDR_STATUS: rd_d[7:0] = ev_q;
      spc_pkg::ADDR_MASK: rd_d[7:0] = mask_q;
      spc_pkg::ADDR_MODE: rd_d[7:0] = {4'h0, mode_q[1], mode_q[0]};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock pin synchroniser, used only when external clock is chosen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_s1_q <= 2'h0;
      sck_s2_q <= 2'h0;
    end else begin
      sck_s1_q <= sck_pin_i;
      sck_s2_q <= sck_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per channel control, filter and request gating
  for (genvar c = 0; c < spc_pkg::N_CH; c++) begin : g_ch
    logic [7:0] cr;
    logic filt_on;
    logic [7:0] ctrl_wadr;
    logic [1:0] mode_sh;
    spc_pkg::spc_irq_t irq_d;
    spc_pkg::spc_ctl_t ctl_d;
    assign cr = ctrl_q[c];
    assign ctrl_wadr = (c == 0) ? spc_pkg::ADDR_CTRL0 : spc_pkg::ADDR_CTRL1;
    // filter works only in async address format
    assign filt_on = cr[spc_pkg::B_AF_IE] && mode_q[c][spc_pkg::M_ADDR_FMT]
                     && !mode_q[c][spc_pkg::M_SYNC];

    always_ff @(posedge clk_i) begin
      if (rst_i || standby_i) begin
        ctrl_q[c] <= spc_pkg::CTRL_RESET;
      end else if (wr_lo && wb_adr_i == ctrl_wadr) begin
        ctrl_q[c] <= wb_dat_i[7:0];
      end else if (filt_on && rx_ev_i[c].valid && rx_ev_i[c].addr_bit) begin
        // hardware clear loses to a software write in the same cycle
        ctrl_q[c][spc_pkg::B_AF_IE] <= 1'b0;
      end
    end

    assign mode_sh = wb_dat_i[2*c +: 2];
    always_ff @(posedge clk_i) begin
      if (rst_i || standby_i) begin
        mode_q[c] <= spc_pkg::MODE_RESET;
      end else if (wr_lo && wb_adr_i == spc_pkg::ADDR_MODE) begin
        mode_q[c] <= mode_sh;
      end
    end

    always_comb begin
      irq_d.tx_empty_irq = cr[spc_pkg::B_TXE_IE] && flags_i[c].tx_buf_empty_flag;
      irq_d.rx_full_irq = cr[spc_pkg::B_RX_IE] && flags_i[c].rx_buf_full_flag;
      irq_d.rx_error_irq = cr[spc_pkg::B_RX_IE] && (flags_i[c].overrun_flag
                           || flags_i[c].framing_flag || flags_i[c].parity_flag);
      irq_d.tx_done_irq = cr[spc_pkg::B_TXD_IE] && flags_i[c].tx_done_flag;
      ctl_d.tx_run = cr[spc_pkg::B_TX_EN];
      ctl_d.txd_pin_out = cr[spc_pkg::B_TX_EN];
      ctl_d.rx_run = cr[spc_pkg::B_RX_EN];
      ctl_d.rxd_pin_in = cr[spc_pkg::B_RX_EN];
      // accept unless filtering and address bit is zero
      ctl_d.rx_accept = rx_ev_i[c].valid && cr[spc_pkg::B_RX_EN]
                        && (!filt_on || rx_ev_i[c].addr_bit);
      ctl_d.rx_addr_bit_set = filt_on && rx_ev_i[c].valid
                              && rx_ev_i[c].addr_bit;
      ctl_d.clk_source_ext = cr[spc_pkg::B_CK_EXT];
      ctl_d.sck_out_en = !cr[spc_pkg::B_CK_EXT] && (mode_q[c][spc_pkg::M_SYNC]
                         || cr[spc_pkg::B_CK_OUT]);
      ctl_d.sck_in = cr[spc_pkg::B_CK_EXT] && sck_s2_q[c];
    end

    // one register stage: requests follow flag or enable by one cycle
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        irq_o[c] <= '0;
        ctl_o[c] <= '0;
      end else begin
        irq_o[c] <= irq_d;
        ctl_o[c] <= ctl_d;
      end
    end

    assign ev_set[4*c +: 4] = {irq_d.tx_empty_irq, irq_d.rx_full_irq,
                               irq_d.rx_error_irq, irq_d.tx_done_irq};
  end

  ////////////////////////////////////////////////////////////////////
  // sticky event status, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_q <= spc_pkg::EV_RESET;
    end else if (wr_lo && wb_adr_i == spc_pkg::ADDR_STATUS) begin
      ev_q <= (ev_q & ~wb_dat_i[7:0]) | ev_set;
    end else begin
      ev_q <= ev_q | ev_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= spc_pkg::EV_RESET;
    end else if (wr_lo && wb_adr_i == spc_pkg::ADDR_MASK) begin
      mask_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o_any <= 1'b0;
    end else begin
      irq_o_any <= |(ev_q & mask_q);
    end
  end
endmodule
`default_nettype wire

// ### verilog/spc_pkg.sv
// package for the serial port control block: offsets, fields, structs
// assumes a 32-bit classic wishbone slave port, byte addressed
`default_nettype none
package spc_pkg;
  // register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  // documented register offsets, kept for reference maps
  localparam logic [15:0] OFS_CTRL_CH1 = 16'hff8a;
  localparam logic [15:0] OFS_CTRL_CH0 = 16'hffda;
  // control register fields
  localparam int B_TXE_IE = 7;
  localparam int B_RX_IE = 6;
  localparam int B_TX_EN = 5;
  localparam int B_RX_EN = 4;
  localparam int B_AF_IE = 3;
  localparam int B_TXD_IE = 2;
  localparam int B_CK_EXT = 1;
  localparam int B_CK_OUT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // mode register fields (own copy of the mode bits this block needs)
  localparam int M_SYNC = 0;
  localparam int M_ADDR_FMT = 1;
  localparam logic [1:0] MODE_RESET = 2'h0;
  // event status bits: one per channel per interrupt kind
  localparam int N_EV = 8;
  localparam logic [7:0] EV_RESET = 8'h00;
  localparam int N_CH = 2;

  // status flags from the serial core of one channel
  typedef struct packed {
    logic tx_buf_empty_flag;
    logic rx_buf_full_flag;
    logic overrun_flag;
    logic framing_flag;
    logic parity_flag;
    logic tx_done_flag;
  } spc_flags_t;

  // receive character event from the shifter of one channel
  typedef struct packed {
    logic valid;
    logic addr_bit;
  } spc_rx_ev_t;

  // controls handed to one channel
  typedef struct packed {
    logic tx_run;
    logic txd_pin_out;
    logic rx_run;
    logic rxd_pin_in;
    logic rx_accept;
    logic rx_addr_bit_set;
    logic clk_source_ext;
    logic sck_out_en;
    logic sck_in;
  } spc_ctl_t;

  // interrupt requests of one channel
  typedef struct packed {
    logic tx_empty_irq;
    logic rx_full_irq;
    logic rx_error_irq;
    logic tx_done_irq;
  } spc_irq_t;
endpackage
`default_nettype wire

// ### bench/spc_monitor.sv
// port checker for the serial port control block, channel 0
// assumes it is bound onto the block and shares its clock
`default_nettype none
module spc_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus and channels
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire spc_pkg::spc_flags_t [1:0] flags_i,
  input wire spc_pkg::spc_rx_ev_t [1:0] rx_ev_i,
  input wire spc_pkg::spc_ctl_t [1:0] ctl_o,
  input wire spc_pkg::spc_irq_t [1:0] irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_reset_clear: assert property ($past(rst_i) |-> ctl_o == '0 && irq_o == '0)
    else $error("not cleared");
  a_txe_gate: assert property (
    irq_o[0].tx_empty_irq |-> $past(flags_i[0].tx_buf_empty_flag)) else $error("txe");
  a_rx_gate: assert property (
    irq_o[0].rx_full_irq |-> $past(flags_i[0].rx_buf_full_flag)) else $error("rx");
  a_err_gate: assert property (
    irq_o[0].rx_error_irq |-> $past(|flags_i[0][3:1])) else $error("err");
  a_txd_gate: assert property (
    irq_o[0].tx_done_irq |-> $past(flags_i[0].tx_done_flag)) else $error("txd");
  a_pin_dirs: assert property (ctl_o[0].txd_pin_out == ctl_o[0].tx_run &&
    ctl_o[0].rxd_pin_in == ctl_o[0].rx_run) else $error("pins");
  a_clk_dir: assert property (
    ctl_o[0].sck_out_en |-> !ctl_o[0].clk_source_ext) else $error("sck");
  a_accept_cause: assert property (
    ctl_o[0].rx_accept |-> $past(rx_ev_i[0].valid)) else $error("accept");
  a_addr_set: assert property (
    ctl_o[0].rx_addr_bit_set |-> ctl_o[0].rx_accept && $past(rx_ev_i[0].addr_bit))
    else $error("addr bit");
endmodule
bind spc_serial_port_control spc_monitor i_spc_monitor (.*);
`default_nettype wire

// ### bench/spc_core_model.sv
// serial core stand-in for channel 0: status flags toward the block
// assumes the bench supplies the line-side flags
`default_nettype none
module spc_core_model (
  // clock
  input wire logic clk_i,
  // control side
  input wire spc_pkg::spc_ctl_t ctl_i,
  input wire logic [5:0] line_i,
  // flags
  output spc_pkg::spc_flags_t flags_o
);
  logic rxf_q;
  // full from accepted chars or line_i, so dropped chars stay invisible
  always_ff @(posedge clk_i) begin
    rxf_q <= ctl_i.rx_run && (rxf_q || ctl_i.rx_accept);
  end
  assign flags_o = line_i | {1'b0, rxf_q, 4'h0};
endmodule
`default_nettype wire

// ### bench/tb.sv
// bench for the serial port control block: bus tasks and scenarios
// assumes the core stand-in model and the bound checker
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, standby_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o_any;
  logic [7:0] wb_adr_i, q;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [5:0] line;
  logic [1:0] sck_pin_i;
  spc_pkg::spc_flags_t f0;
  spc_pkg::spc_rx_ev_t ev;
  spc_pkg::spc_ctl_t [1:0] ctl_o;
  spc_pkg::spc_irq_t [1:0] irq_o;
  int fails, cmp_count, cyc_n, acc;
  spc_serial_port_control i_spc_serial_port_control (.*, .wb_sel_i(4'hf),
    .flags_i({6'h00, f0}), .rx_ev_i({2'h0, ev}));
  spc_core_model i_spc_core_model (.clk_i(clk_i), .ctl_i(ctl_o[0]), .line_i(line),
    .flags_o(f0));
  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    acc <= acc + ctl_o[0].rx_accept;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      fails++;
      end_of_test();
    end
  end
  //////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(q, e);
  endtask
  task automatic send(input logic b);
    ev <= '{1'b1, b};
    tick(1);
    ev <= '0;
    tick(3);
  endtask
  //////////////////////////////////////////////////////////////////
  task automatic t_irq();
    rd(8'h04, 8'h00);
    bus(8'h04, 1'b1, 8'ha5);
    rd(8'h04, 8'ha5);
    chk(ctl_o[1], 9'h182);
    bus(8'h20, 1'b1, 8'hff);
    rd(8'h20, 8'h00);
    line <= 6'h29;
    bus(8'h00, 1'b1, 8'hc4);
    tick(2);
    chk(irq_o[0], 4'hb);
    for (int i = 0; i < 3; i++) begin
      line <= 6'h08 >> i;
      tick(2);
      chk(irq_o[0], 4'h2);
    end
    bus(8'h00, 1'b1, 8'h00);
    tick(2);
    chk(irq_o[0], 4'h0);
    line <= 6'h00;
    rd(8'h08, 8'h0b);
    chk(irq_o_any, 1'b0);
    bus(8'h0c, 1'b1, 8'h01);
    tick(2);
    chk(irq_o_any, 1'b1);
    bus(8'h08, 1'b1, 8'h0f);
    rd(8'h08, 8'h00);
    chk(irq_o_any, 1'b0);
    $display("irq test done");
  endtask
  task automatic t_filt();
    bus(8'h10, 1'b1, 8'h02);
    bus(8'h00, 1'b1, 8'h58);
    send(1'b0);
    chk(acc, 0);
    chk(irq_o[0], 4'h0);
    send(1'b1);
    chk(acc, 1);
    rd(8'h00, 8'h50);
    chk(irq_o[0], 4'h4);
    send(1'b0);
    chk(acc, 2);
    bus(8'h10, 1'b1, 8'h03);
    bus(8'h00, 1'b1, 8'h58);
    send(1'b0);
    chk(acc, 3);
    $display("filter test done");
  endtask
  task automatic t_pins();
    logic [7:0] m [3] = '{8'h00, 8'h00, 8'h01};
    logic [7:0] c [3] = '{8'h31, 8'h03, 8'h00};
    logic [8:0] e [3] = '{9'h1e2, 9'h005, 9'h002};
    sck_pin_i <= 2'h1;
    for (int i = 0; i < 3; i++) begin
      bus(8'h10, 1'b1, m[i]);
      bus(8'h00, 1'b1, c[i]);
      tick(4);
      chk(ctl_o[0], e[i]);
    end
    bus(8'h00, 1'b1, 8'hff);
    standby_i <= 1'b1;
    tick(1);
    standby_i <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h10, 8'h00);
    $display("pin test done");
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {rst_i, standby_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h10;
    {wb_adr_i, wb_dat_i, line, sck_pin_i, ev} = '0;
    {fails, cmp_count, cyc_n, acc} = '0;
    tick(20);
    rst_i <= 1'b0;
    tick(1);
    t_irq();
    t_filt();
    t_pins();
    end_of_test();
  end
endmodule
`default_nettype wire
